// File: rtl/regulator_control_pkg.sv
// constants and types for the regulator control register bank
package regulator_control_pkg;
  // slave identities on the control port
  localparam logic [6:0] SLAVE_DYNAMIC_VOLTAGE_SCALING = 7'h12;
  localparam logic [6:0] SLAVE_CTL  = 7'h48;
  // register offsets
  localparam logic [7:0] OFS_BUCK2_FORCE   = 8'h5B;
  localparam logic [7:0] OFS_BUCK2_NOMINAL = 8'h5C;
  localparam logic [7:0] OFS_BUCK2_STEP    = 8'h5D;
  localparam logic [7:0] OFS_BUCK3_TRANS   = 8'h65;
  localparam logic [7:0] OFS_BUCK3_STATE   = 8'h66;
  localparam logic [7:0] OFS_BUCK3_VOLTAGE = 8'h68;
  localparam logic [7:0] OFS_ANA_TRANS     = 8'h81;
  localparam logic [7:0] OFS_ANA_STATE     = 8'h82;
  localparam logic [7:0] OFS_ANA_VOLTAGE   = 8'h83;
  localparam logic [7:0] OFS_LIN2_TRANS    = 8'h85;
  // field positions
  localparam int CMD_MSB     = 7;
  localparam int CMD_LSB     = 6;
  localparam int WARM_BIT    = 7;
  localparam int NORAMP_BIT  = 7;
  // reset values
  localparam logic [1:0] CMD_RST     = 2'h0;
  localparam logic [4:0] STEP_RST    = 5'h06;
  localparam logic [5:0] TRANS_RST   = 6'h05;
  localparam logic [1:0] STATE_RST   = 2'h0;
  // hard minimum step delay, 6 cycles of the 6 MHz step clock
  localparam logic [4:0] STEP_MIN    = 5'h06;
  localparam logic [7:0] LDO_CODE_MAX   = 8'h18;
  localparam logic [7:0] LDO_CODE_FIXED = 8'h1F;
  // command, mode and state types (warm reset acts on the falling edge of warm_rst_b)
  typedef enum logic [1:0] {
    FCMD_FORCE_ACTIVE, FCMD_ACTIVE, FCMD_OFF_OR_SLEEP, FCMD_SLEEP
  } force_cmd_t;
  typedef enum logic [1:0] {
    MODE_OFF, MODE_AUTO, MODE_RSVD, MODE_FULL
  } trans_mode_t;
  typedef enum logic [1:0] {
    RES_OFF, RES_ON, RES_SLEEP
  } res_state_t;
  typedef enum logic [1:0] {
    REG_OFF, REG_FORCE_SLEEP, REG_SLEEP, REG_ACTIVE
  } buck_op_t;
endpackage : regulator_control_pkg

// File: rtl/regulator_control_regs.sv
// register bank and decode for buck 2/3 and the analog and linear 2 LDOs
// ----------------------------------------------------------------
// Summary of operation
// ----------------------------------------------------------------
// Summary of operation
// - force cmd 00 forced active, 01 active
// - cmd 10: zero code off, else force sleep; 11 sleep
// - nominal code in cmd 01, forced code in cmds 00, 10 and 11
// - warm reset reloads default unless sensitivity set
// - no-ramp bit applies voltage directly
// - step delay floored at six cycles
// - buck transition codes off, auto, forced pwm
// - ldo transition codes off, auto switching, active
// - active, sleep, off fields; bits 7:6 zero
// - state 00/10 off, 01 on, 11 sleep
// - ldo code table: zero, levels, reserved, fixed
// - shared ldo table; rtc supply fixed
`timescale 1ns/1ns
`default_nettype none
module regulator_control_regs (
  // clock and resets
  input  wire logic       ref_clk,
  input  wire logic       rst_b,
  input  wire logic       backup_rst_b,
  input  wire logic       warm_rst_b,
  // nonvolatile default voltage codes
  input  wire logic [5:0] nv_buck2_code,
  input  wire logic [5:0] nv_buck3_code,
  input  wire logic [4:0] nv_ana_code,
  // decoded register port of the control interface
  input  wire logic [6:0] slave_id,
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  output logic            reg_ack,
  // regulator controls
  input  wire logic       step_tick,
  output logic      [1:0] buck2_op,
  output logic      [5:0] buck2_voltage_code,
  output logic            buck2_ramp_busy,
  output logic      [1:0] buck3_active_state_cmd,
  output logic      [1:0] buck3_state_req,
  output logic      [5:0] buck3_voltage_code,
  output logic      [1:0] ana_active_state_cmd,
  output logic      [1:0] ana_state_req,
  output logic      [4:0] ana_voltage_code,
  output logic            ana_code_valid,
  output logic            ana_code_fixed_level,
  output logic      [1:0] lin2_active_state_cmd
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0] b2_cmd;
    logic [5:0] b2_fcode;
    logic [5:0] b2_ncode;
    logic       b2_noramp;
    logic [4:0] b2_step;
    logic [5:0] b2_out;
    logic [4:0] b2_cnt;
    logic [5:0] b3_trans;
    logic [1:0] b3_state;
    logic [5:0] b3_code;
    logic [5:0] ana_trans;
    logic [1:0] ana_state;
    logic [4:0] ana_code;
    logic [5:0] l2_trans;
    logic       seeded;
    logic [7:0] rdata;
    logic       ack;
  } state_t;

  state_t st_r;
  state_t st_nxt;
  // sensitivity bits live in the backup domain
  logic [2:0] warm_keep_r;
  logic [2:0] warm_keep_nxt;
  logic       warm_d_r;

  logic       scaling_sel;
  logic       ctl_sel;
  logic [5:0] b2_target;
  logic       b2_forced;
  logic [4:0] b2_delay;
  logic       warm_edge;

  assign scaling_sel = slave_id ==
                       regulator_control_pkg::SLAVE_DYNAMIC_VOLTAGE_SCALING;
  assign ctl_sel   = slave_id == regulator_control_pkg::SLAVE_CTL;
  assign b2_forced = st_r.b2_cmd != 2'h1;
  assign b2_target = b2_forced ? st_r.b2_fcode : st_r.b2_ncode;
  // hard floor on the step interval
  assign b2_delay  = (st_r.b2_step < regulator_control_pkg::STEP_MIN) ?
                     regulator_control_pkg::STEP_MIN : st_r.b2_step;
  assign warm_edge = ~warm_rst_b & warm_d_r;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    st_nxt        = st_r;
    warm_keep_nxt = warm_keep_r;
    st_nxt.ack    = reg_wr | reg_rd;
    // codes come from nonvolatile memory after reset
    if (!st_r.seeded)
    begin
      st_nxt.b2_fcode = nv_buck2_code;
      st_nxt.b2_ncode = nv_buck2_code;
      st_nxt.b2_out   = nv_buck2_code;
      st_nxt.b3_code  = nv_buck3_code;
      st_nxt.ana_code = nv_ana_code;
      st_nxt.seeded   = 1'b1;
    end
    else if (warm_edge)
    begin
      // warm reset touches only codes whose keep bit is clear
      if (!warm_keep_r[0])
      begin
        st_nxt.b2_ncode = nv_buck2_code;
        st_nxt.b2_fcode = nv_buck2_code;
      end
      if (!warm_keep_r[1])
        st_nxt.b3_code = nv_buck3_code;
      if (!warm_keep_r[2])
        st_nxt.ana_code = nv_ana_code;
    end
    else if (reg_wr && scaling_sel)
    begin
      unique case (reg_addr)
        regulator_control_pkg::OFS_BUCK2_FORCE:
        begin
          st_nxt.b2_cmd   = reg_wdata[7:6];
          st_nxt.b2_fcode = reg_wdata[5:0];
        end
        regulator_control_pkg::OFS_BUCK2_NOMINAL:
        begin
          st_nxt.b2_ncode  = reg_wdata[5:0];
          warm_keep_nxt[0] = reg_wdata[regulator_control_pkg::WARM_BIT];
        end
        default: ;
      endcase
    end
    else if (reg_wr && ctl_sel)
    begin
      unique case (reg_addr)
        regulator_control_pkg::OFS_BUCK2_STEP:
        begin
          st_nxt.b2_noramp = reg_wdata[regulator_control_pkg::NORAMP_BIT];
          st_nxt.b2_step   = reg_wdata[4:0];
        end
        // only the active-state field is writable
        regulator_control_pkg::OFS_BUCK3_TRANS:
          st_nxt.b3_trans[1:0] = reg_wdata[1:0];
        regulator_control_pkg::OFS_BUCK3_STATE:
          st_nxt.b3_state = reg_wdata[1:0];
        regulator_control_pkg::OFS_BUCK3_VOLTAGE:
        begin
          st_nxt.b3_code   = reg_wdata[5:0];
          warm_keep_nxt[1] = reg_wdata[regulator_control_pkg::WARM_BIT];
        end
        regulator_control_pkg::OFS_ANA_TRANS:
          st_nxt.ana_trans[1:0] = reg_wdata[1:0];
        regulator_control_pkg::OFS_ANA_STATE:
          st_nxt.ana_state = reg_wdata[1:0];
        regulator_control_pkg::OFS_ANA_VOLTAGE:
        begin
          st_nxt.ana_code  = reg_wdata[4:0];
          warm_keep_nxt[2] = reg_wdata[regulator_control_pkg::WARM_BIT];
        end
        regulator_control_pkg::OFS_LIN2_TRANS:
          st_nxt.l2_trans[1:0] = reg_wdata[1:0];
        default: ;
      endcase
    end

    // read data; reserved bits read zero, unmapped reads zero
    st_nxt.rdata = 8'h00;
    if (reg_rd && scaling_sel)
    begin
      unique case (reg_addr)
        regulator_control_pkg::OFS_BUCK2_FORCE:
          st_nxt.rdata = {st_r.b2_cmd, st_r.b2_fcode};
        regulator_control_pkg::OFS_BUCK2_NOMINAL:
          st_nxt.rdata = {warm_keep_r[0], 1'b0, st_r.b2_ncode};
        default: ;
      endcase
    end
    else if (reg_rd && ctl_sel)
    begin
      unique case (reg_addr)
        regulator_control_pkg::OFS_BUCK2_STEP:
          st_nxt.rdata = {st_r.b2_noramp, 2'h0, st_r.b2_step};
        regulator_control_pkg::OFS_BUCK3_TRANS:
          st_nxt.rdata = {2'h0, st_r.b3_trans};
        regulator_control_pkg::OFS_BUCK3_STATE:
          st_nxt.rdata = {6'h00, st_r.b3_state};
        regulator_control_pkg::OFS_BUCK3_VOLTAGE:
          st_nxt.rdata = {warm_keep_r[1], 1'b0, st_r.b3_code};
        regulator_control_pkg::OFS_ANA_TRANS:
          st_nxt.rdata = {2'h0, st_r.ana_trans};
        regulator_control_pkg::OFS_ANA_STATE:
          st_nxt.rdata = {6'h00, st_r.ana_state};
        regulator_control_pkg::OFS_ANA_VOLTAGE:
          st_nxt.rdata = {warm_keep_r[2], 2'h0, st_r.ana_code};
        regulator_control_pkg::OFS_LIN2_TRANS:
          st_nxt.rdata = {2'h0, st_r.l2_trans};
        default: ;
      endcase
    end

    // ramp of the applied buck 2 code towards the target
    // seeding already puts the default code on the output, no ramp from 0
    if (!st_r.seeded)
      st_nxt.b2_cnt = 5'h00;
    else if (st_r.b2_noramp)
    begin
      st_nxt.b2_out = b2_target;
      st_nxt.b2_cnt = 5'h00;
    end
    else if (st_r.b2_out == b2_target)
      st_nxt.b2_cnt = 5'h00;
    else if (step_tick)
    begin
      // one code step per programmed interval (at least six) of step clock ticks
      if (st_r.b2_cnt + 5'h01 >= b2_delay)
      begin
        st_nxt.b2_cnt = 5'h00;
        st_nxt.b2_out = (st_r.b2_out < b2_target) ?
                        st_r.b2_out + 6'h01 : st_r.b2_out - 6'h01;
      end
      else
        st_nxt.b2_cnt = st_r.b2_cnt + 5'h01;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_r           <= '0;
      st_r.b2_cmd    <= regulator_control_pkg::CMD_RST;
      st_r.b2_step   <= regulator_control_pkg::STEP_RST;
      st_r.b3_trans  <= regulator_control_pkg::TRANS_RST;
      st_r.ana_trans <= regulator_control_pkg::TRANS_RST;
      st_r.l2_trans  <= regulator_control_pkg::TRANS_RST;
      st_r.b3_state  <= regulator_control_pkg::STATE_RST;
      st_r.ana_state <= regulator_control_pkg::STATE_RST;
      warm_d_r       <= 1'b1;
    end
    else
    begin
      st_r     <= st_nxt;
      warm_d_r <= warm_rst_b;
    end
  end

  // a state reset leaves the sensitivity bits alone
  always_ff @(posedge ref_clk or negedge backup_rst_b)
  begin
    if (!backup_rst_b)
      warm_keep_r <= 3'h0;
    else
      warm_keep_r <= warm_keep_nxt;
  end

  // ----------------------------------------------------------------
  // decoded outputs
  // ----------------------------------------------------------------
  always_comb
  begin
    unique case (regulator_control_pkg::force_cmd_t'(st_r.b2_cmd))
      regulator_control_pkg::FCMD_FORCE_ACTIVE:
        buck2_op = 2'(regulator_control_pkg::REG_ACTIVE);
      regulator_control_pkg::FCMD_ACTIVE:
        buck2_op = 2'(regulator_control_pkg::REG_ACTIVE);
      regulator_control_pkg::FCMD_OFF_OR_SLEEP:
        buck2_op = (st_r.b2_fcode == 6'h00) ?
                   2'(regulator_control_pkg::REG_OFF) :
                   2'(regulator_control_pkg::REG_FORCE_SLEEP);
      regulator_control_pkg::FCMD_SLEEP:
        buck2_op = 2'(regulator_control_pkg::REG_SLEEP);
    endcase
  end

  assign reg_rdata              = st_r.rdata;
  assign reg_ack                = st_r.ack;
  assign buck2_voltage_code     = st_r.b2_out;
  // busy until seeded, so the first applied code is not taken as settled
  assign buck2_ramp_busy        = !st_r.seeded ||
                                  (st_r.b2_out != b2_target);
  // buck: off / auto pwm-pfm / forced pwm; ldo: off / auto / active
  assign buck3_active_state_cmd = st_r.b3_trans[1:0];
  assign ana_active_state_cmd   = st_r.ana_trans[1:0];
  assign lin2_active_state_cmd  = st_r.l2_trans[1:0];
  // 10 also requests off
  assign buck3_state_req = (st_r.b3_state == 2'h2) ? 2'h0 : st_r.b3_state;
  assign ana_state_req = (st_r.ana_state == 2'h2) ? 2'h0 : st_r.ana_state;
  assign buck3_voltage_code     = st_r.b3_code;
  assign ana_voltage_code       = st_r.ana_code;
  // shared ldo table; the rtc supply has no code and is not here
  assign ana_code_valid = ({3'h0, st_r.ana_code}
                           <= regulator_control_pkg::LDO_CODE_MAX) ||
                          ({3'h0, st_r.ana_code}
                           == regulator_control_pkg::LDO_CODE_FIXED);
  assign ana_code_fixed_level = {3'h0, st_r.ana_code}
                                == regulator_control_pkg::LDO_CODE_FIXED;

endmodule : regulator_control_regs
`default_nettype wire

// File: testbench/regulator_control_checker.sv
// port-level checks of the regulator control register bank
`timescale 1ns/1ns
`default_nettype none
module regulator_control_checker (
  // clock and reset
  input wire logic       ref_clk,
  input wire logic       rst_b,
  // register port
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_rdata,
  input wire logic       reg_ack,
  // regulator controls
  input wire logic       buck2_ramp_busy,
  input wire logic [5:0] buck2_voltage_code,
  input wire logic [1:0] buck3_state_req,
  input wire logic [1:0] ana_state_req,
  input wire logic [4:0] ana_voltage_code,
  input wire logic       ana_code_valid,
  input wire logic       ana_code_fixed_level
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);

  AST_ACK_PULSE: assert property ((reg_wr || reg_rd) |=> reg_ack)
    else $error("strobe not acknowledged next cycle");
  AST_NO_ACK: assert property (!(reg_wr || reg_rd) |=> !reg_ack)
    else $error("acknowledge without a strobe");
  AST_RD_IDLE: assert property (!reg_ack |-> reg_rdata == 8'h00)
    else $error("read data outside the answer cycle");
  AST_TRANS_TOP: assert property (reg_ack && $past(reg_rd) &&
    $past(reg_addr) == regulator_control_pkg::OFS_BUCK3_TRANS
    |-> reg_rdata[7:6] == 2'h0)
    else $error("transition register top bits not zero");
  AST_STATE_MAP: assert property (buck3_state_req != 2'h2 &&
    ana_state_req != 2'h2)
    else $error("state request shows code 10");
  AST_FIXED: assert property (ana_code_fixed_level ==
    (ana_voltage_code == 5'h1F))
    else $error("fixed level flag wrong");
  AST_VALID: assert property (ana_code_valid ==
    (ana_voltage_code <= 5'h18 || ana_voltage_code == 5'h1F))
    else $error("code valid flag wrong");
  AST_APPLY: assert property ($changed(buck2_voltage_code)
    |-> $past(buck2_ramp_busy))
    else $error("applied code moved while not busy");
endmodule : regulator_control_checker

bind regulator_control_regs regulator_control_checker u_chk (
  .ref_clk, .rst_b, .reg_wr, .reg_rd, .reg_addr, .reg_rdata, .reg_ack,
  .buck2_ramp_busy, .buck2_voltage_code, .buck3_state_req,
  .ana_state_req, .ana_voltage_code, .ana_code_valid,
  .ana_code_fixed_level);
`default_nettype wire

// File: testbench/ctl_host.sv
// host model on the decoded register port
`timescale 1ns/1ns
`default_nettype none
module ctl_host (
  // clock
  input  wire logic       ref_clk,
  // register port
  output logic      [6:0] slave_id,
  output logic      [7:0] reg_addr,
  output logic            reg_wr,
  output logic            reg_rd,
  output logic      [7:0] reg_wdata,
  input  wire logic [7:0] reg_rdata,
  input  wire logic       reg_ack
);
  logic [7:0] q;
  logic       got;
  initial
  begin
    slave_id  = 7'h00;
    reg_addr  = 8'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_wdata = 8'h00;
  end
  // single byte, one-cycle strobe, answer sampled in the ack cycle
  task acc(input logic w, input logic [6:0] id, input logic [7:0] a,
           input logic [7:0] d);
    @(posedge ref_clk);
    slave_id  <= id;
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= w;
    reg_rd    <= ~w;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    #1;
    got = reg_ack;
    q   = reg_rdata;
  endtask : acc
endmodule : ctl_host
`default_nettype wire

// File: testbench/tb_regulator_control_regs.sv
// self-checking bench for the regulator control register bank
`timescale 1ns/1ns
`default_nettype none
module tb_regulator_control_regs;
  logic       ref_clk = 1'b0;
  logic       rst_b, backup_rst_b, warm_rst_b;
  logic       step_tick = 1'b0;
  logic [6:0] slave_id;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic       reg_wr, reg_rd, reg_ack, buck2_ramp_busy;
  logic [1:0] buck2_op, b3_cmd, ana_cmd, l2_cmd, b3_req, ana_req;
  logic [5:0] buck2_voltage_code, buck3_voltage_code;
  logic [4:0] ana_voltage_code;
  logic       ana_code_valid, ana_code_fixed_level;
  int         failures = 0;
  int         n_tests = 0;
  int         cyc = 0;
  logic [7:0] adr [10] = '{8'h5B, 8'h5C, 8'h5D, 8'h65, 8'h66, 8'h68,
                           8'h81, 8'h82, 8'h83, 8'h85};
  logic [7:0] rv [10] = '{8'h14, 8'h14, 8'h06, 8'h05, 8'h00, 8'h21,
                          8'h05, 8'h00, 8'h0C, 8'h05};
  logic [4:0] lc [4] = '{5'h00, 5'h18, 5'h19, 5'h1F};

  always #20 ref_clk = ~ref_clk;
  // step clock pulse every other reference cycle
  always @(posedge ref_clk) step_tick <= ~step_tick;

  ctl_host u_host (.ref_clk, .slave_id, .reg_addr, .reg_wr, .reg_rd,
                   .reg_wdata, .reg_rdata, .reg_ack);
  regulator_control_regs DUT (.ref_clk, .rst_b, .backup_rst_b,
    .warm_rst_b, .nv_buck2_code(6'h14), .nv_buck3_code(6'h21),
    .nv_ana_code(5'h0C), .slave_id, .reg_addr, .reg_wr, .reg_rd,
    .reg_wdata, .reg_rdata, .reg_ack, .step_tick, .buck2_op,
    .buck2_voltage_code, .buck2_ramp_busy, .buck3_active_state_cmd(b3_cmd),
    .buck3_state_req(b3_req), .buck3_voltage_code,
    .ana_active_state_cmd(ana_cmd), .ana_state_req(ana_req),
    .ana_voltage_code, .ana_code_valid, .ana_code_fixed_level,
    .lin2_active_state_cmd(l2_cmd));

  task conclude;
    $display("tests %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : conclude

  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      failures++;
      conclude();
    end
  end

  task chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      failures++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk

  task xf(input logic w, input logic [6:0] id, input logic [7:0] a,
          input logic [7:0] d, input logic [7:0] e);
    u_host.acc(w, id, a, d);
    chk({7'h0, u_host.got}, 8'h01);
    if (!w)
      chk(u_host.q, e);
  endtask : xf

  function automatic logic [6:0] sid(input logic [7:0] a);
    return (a < 8'h5D) ? regulator_control_pkg::SLAVE_DYNAMIC_VOLTAGE_SCALING
                       : regulator_control_pkg::SLAVE_CTL;
  endfunction : sid

  task wr(input logic [7:0] a, input logic [7:0] d);
    xf(1'b1, sid(a), a, d, 8'h00);
  endtask : wr

  task rd(input logic [7:0] a, input logic [7:0] e);
    xf(1'b0, sid(a), a, 8'h00, e);
  endtask : rd

  // cycles of busy after a retarget; floor of six ticks per step
  task ramp(input logic [7:0] st, input logic [7:0] f, input int lo,
            input int hi);
    int n;
    n = 0;
    wr(8'h5D, st);
    wr(8'h5B, f);
    while (buck2_ramp_busy !== 1'b0 && n < 300)
    begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    chk({7'h0, n >= lo && n <= hi}, 8'h01);
  endtask : ramp

  task pulse(input logic warm);
    @(posedge ref_clk);
    if (warm)
      warm_rst_b <= 1'b0;
    else
      backup_rst_b <= 1'b0;
    repeat (2) @(posedge ref_clk);
    warm_rst_b   <= 1'b1;
    backup_rst_b <= 1'b1;
    repeat (2) @(posedge ref_clk);
  endtask : pulse

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    logic [1:0] e;
    rst_b = 1'b0;
    backup_rst_b = 1'b0;
    warm_rst_b = 1'b1;
    repeat (10) @(posedge ref_clk);
    rst_b <= 1'b1;
    backup_rst_b <= 1'b1;
    repeat (2) @(posedge ref_clk);
    for (int i = 0; i < 10; i++)
      rd(adr[i], rv[i]);
    chk({2'h0, buck2_voltage_code}, 8'h14);
    chk({2'h0, buck3_voltage_code}, 8'h21);
    xf(1'b1, 7'h48, 8'h5B, 8'hC0, 8'h00);
    xf(1'b0, 7'h48, 8'h5B, 8'h00, 8'h00);
    xf(1'b0, 7'h48, 8'h70, 8'h00, 8'h00);
    rd(8'h5B, 8'h14);
    wr(8'h5D, 8'h80);
    for (int c = 0; c < 5; c++)
    begin
      e = (c == 4) ? 2'h2 : c[1:0];
      wr(8'h5B, {e, (c == 4) ? 6'h00 : 6'h15});
      chk({6'h0, buck2_op}, (e < 2) ? 8'h03 : (e == 3) ? 8'h02 :
          (c == 4) ? 8'h00 : 8'h01);
    end
    wr(8'h5C, 8'h0B);
    wr(8'h5B, 8'h55);
    repeat (2) @(posedge ref_clk);
    chk({2'h0, buck2_voltage_code}, 8'h0B);
    wr(8'h5B, 8'h21);
    repeat (2) @(posedge ref_clk);
    chk({2'h0, buck2_voltage_code}, 8'h21);
    ramp(8'h02, 8'h23, 20, 26);
    ramp(8'h0A, 8'h21, 36, 42);
    wr(8'h5C, 8'h05);
    pulse(1'b1);
    rd(8'h5C, 8'h14);
    wr(8'h5C, 8'h85);
    pulse(1'b1);
    rd(8'h5C, 8'h85);
    pulse(1'b0);
    rd(8'h5C, 8'h05);
    for (int t = 0; t < 4; t++)
    begin
      for (int i = 3; i < 10; i = i + 3)
        wr(adr[i], {6'h3F, t[1:0]});
      rd(8'h85, {6'h01, t[1:0]});
      chk({2'h0, b3_cmd, ana_cmd, l2_cmd}, {2'h0, {3{t[1:0]}}});
      wr(8'h66, {6'h3F, t[1:0]});
      wr(8'h82, {6'h3F, t[1:0]});
      rd(8'h66, {6'h00, t[1:0]});
      e = (t == 2) ? 2'h0 : t[1:0];
      chk({4'h0, b3_req, ana_req}, {4'h0, e, e});
    end
    for (int i = 0; i < 4; i++)
    begin
      wr(8'h83, {3'h0, lc[i]});
      rd(8'h83, {3'h0, lc[i]});
      chk({3'h0, ana_voltage_code}, {3'h0, lc[i]});
      chk({6'h0, ana_code_valid, ana_code_fixed_level},
          {6'h0, lc[i] <= 5'h18 || lc[i] == 5'h1F, lc[i] == 5'h1F});
    end
    conclude();
  end
endmodule : tb_regulator_control_regs
`default_nettype wire
